// file: pkg/apm1_regs.vh
// Offsets, field positions and reset values of the PM1 event block
`ifndef APM1_REGS_VH
`define APM1_REGS_VH

// ----------------------------------------------------------------
// Runtime register offsets (host view)
// ----------------------------------------------------------------
`define APM1_OFS_STATUS_ONE   8'h00
`define APM1_OFS_STATUS_TWO   8'h01
`define APM1_OFS_ENABLE_ONE   8'h02
`define APM1_OFS_ENABLE_TWO   8'h03
`define APM1_OFS_CONTROL_ONE  8'h04
`define APM1_OFS_CONTROL_TWO  8'h05
`define APM1_OFS_PM2_CTL_ONE  8'h06
`define APM1_OFS_PM2_CTL_TWO  8'h07

// ----------------------------------------------------------------
// Status two fields
// ----------------------------------------------------------------
`define APM1_STS_POWER_BUTTON    0
`define APM1_STS_SLEEP_BUTTON    1
`define APM1_STS_RTC_ALARM       2
`define APM1_STS_POWER_OVERRIDE  3
`define APM1_STS_WAKE            7
`define APM1_STS_MASK            8'h8F

// ----------------------------------------------------------------
// Enable two fields
// ----------------------------------------------------------------
`define APM1_EN_POWER_BUTTON     0
`define APM1_EN_SLEEP_BUTTON     1
`define APM1_EN_RTC_ALARM        2
`define APM1_EN_MASK             8'h07

// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define APM1_CTL_OVERRIDE_EN     1
`define APM1_CTL_SLEEP_TYPE_LO   2
`define APM1_CTL_SLEEP_TYPE_HI   4
`define APM1_CTL_SLEEP_EN        5
`define APM1_CTL_MASK            8'h3E

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define APM1_RST_STATUS          8'h00
`define APM1_RST_ENABLE          8'h00
`define APM1_RST_CONTROL         8'h00
`define APM1_RST_FW_REQUEST      1'h0

`endif

// file: rtl/apm1_status_bit.v
// One status bit set and cleared by firmware, cleared by host write-one
`timescale 1ns/10ps

module apm1_status_bit
(
  CLK_SYS,
  RST_B,
  ec_wr,
  ec_data,
  host_wr,
  host_data,
  q,
  next_q
);
  input  wire CLK_SYS;
  input  wire RST_B;
  input  wire ec_wr;
  input  wire ec_data;
  input  wire host_wr;
  input  wire host_data;
  output reg  q;
  output reg  next_q;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // Firmware write wins over a host clear in the same cycle
  always @*
  begin
    next_q = q;
    if (host_wr && host_data)
    begin
      next_q = 1'h0;
    end
    if (ec_wr)
    begin
      next_q = ec_data;
    end
  end

  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      q <= 1'h0;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule // apm1_status_bit

// file: rtl/apm1_host_reg.v
// Host-owned byte register that pulses an interrupt on each host write
`timescale 1ns/10ps

module apm1_host_reg
#(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] MASK  = 8'hFF,
  parameter [WIDTH-1:0] RESET = 8'h00
)
(
  CLK_SYS,
  RST_B,
  wr,
  wdata,
  ec_clr,
  q,
  next_q,
  wr_irq
);
  input  wire             CLK_SYS;
  input  wire             RST_B;
  input  wire             wr;
  input  wire [WIDTH-1:0] wdata;
  input  wire [WIDTH-1:0] ec_clr;
  output reg  [WIDTH-1:0] q;
  output reg  [WIDTH-1:0] next_q;
  output reg              wr_irq;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // Firmware may only clear bits, never write them
  always @*
  begin
    next_q = q & ~(ec_clr & MASK);
    if (wr)
    begin
      next_q = wdata & MASK;
    end
  end

  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      q      <= RESET;
      wr_irq <= 1'h0;
    end
    else
    begin
      q      <= next_q;
      wr_irq <= wr;
    end
  end
endmodule // apm1_host_reg

// file: rtl/apm1_event_block.v
// PM1 event block: status, enable, control bits and the host SCI line
`timescale 1ns/10ps
`include "apm1_regs.vh"

module apm1_event_block
(
  CLK_SYS,
  RST_B,
  HOST_WR_STATUS,
  HOST_WR_ENABLE,
  HOST_WR_CONTROL,
  HOST_WDATA,
  EC_WR_STATUS,
  EC_STATUS_DATA,
  EC_WR_SCI_REQUEST,
  HOST_SCI_OUT_N_REQUEST_DATA,
  EC_CLR_SLEEP_EN,
  LOW_POWER_REQ,
  STATUS_TWO,
  ENABLE_TWO,
  CONTROL_TWO,
  FIRMWARE_SCI_REQUEST,
  POWER_OVERRIDE_ENABLE,
  SLEEP_TYPE,
  SLEEP_ENABLE,
  HOST_SCI_OUT_N,
  HOST_CONTROL_WRITE_IRQ,
  HOST_ENABLE_WRITE_IRQ,
  HOST_STATUS_WRITE_IRQ,
  LOW_POWER_ACK
);
  input  wire       CLK_SYS;
  input  wire       RST_B;
  input  wire       HOST_WR_STATUS;
  input  wire       HOST_WR_ENABLE;
  input  wire       HOST_WR_CONTROL;
  input  wire [7:0] HOST_WDATA;
  input  wire       EC_WR_STATUS;
  input  wire [7:0] EC_STATUS_DATA;
  input  wire       EC_WR_SCI_REQUEST;
  input  wire       HOST_SCI_OUT_N_REQUEST_DATA;
  input  wire       EC_CLR_SLEEP_EN;
  input  wire       LOW_POWER_REQ;
  output wire [7:0] STATUS_TWO;
  output wire [7:0] ENABLE_TWO;
  output wire [7:0] CONTROL_TWO;
  output reg        FIRMWARE_SCI_REQUEST;
  output reg        POWER_OVERRIDE_ENABLE;
  output reg  [2:0] SLEEP_TYPE;
  output reg        SLEEP_ENABLE;
  output reg        HOST_SCI_OUT_N;
  output wire       HOST_CONTROL_WRITE_IRQ;
  output wire       HOST_ENABLE_WRITE_IRQ;
  output wire       HOST_STATUS_WRITE_IRQ;
  output reg        LOW_POWER_ACK;

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  wire [7:0] status;
  wire [7:0] next_status;
  wire [7:0] enable;
  wire [7:0] next_enable;
  wire [7:0] control;
  wire [7:0] next_control;
  wire [7:0] control_clr;
  reg        next_fw_request;
  reg        next_sci_n;
  reg        next_low_power_ack;
  wire       status_irq;
  wire       enable_irq;
  wire       control_irq;

  // ----------------------------------------------------------------
  // Status two bits
  // ----------------------------------------------------------------
  // Unimplemented positions are tied off so they always read zero
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_status
      if (((`APM1_STS_MASK >> i) & 1) == 1)
      begin : g_cell
        apm1_status_bit u_bit
        (
          .CLK_SYS   (CLK_SYS),
          .RST_B     (RST_B),
          .ec_wr     (EC_WR_STATUS),
          .ec_data   (EC_STATUS_DATA[i]),
          .host_wr   (HOST_WR_STATUS),
          .host_data (HOST_WDATA[i]),
          .q         (status[i]),
          .next_q    (next_status[i])
        );
      end
      else
      begin : g_none
        assign status[i]      = 1'h0;
        assign next_status[i] = 1'h0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host status write event
  // ----------------------------------------------------------------
  // Reuses a host register only for its write pulse; no data kept
  apm1_host_reg
  #(
    .WIDTH (1),
    .MASK  (1'h0),
    .RESET (1'h0)
  )
  u_status_wr
  (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .wr      (HOST_WR_STATUS),
    .wdata   (HOST_WDATA[0]),
    .ec_clr  (1'h0),
    .q       (),
    .next_q  (),
    .wr_irq  (status_irq)
  );

  // ----------------------------------------------------------------
  // Enable two register
  // ----------------------------------------------------------------
  // Firmware has no write path here, it only sees the outputs
  apm1_host_reg
  #(
    .WIDTH (8),
    .MASK  (`APM1_EN_MASK),
    .RESET (`APM1_RST_ENABLE)
  )
  u_enable
  (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .wr      (HOST_WR_ENABLE),
    .wdata   (HOST_WDATA),
    .ec_clr  (8'h00),
    .q       (enable),
    .next_q  (next_enable),
    .wr_irq  (enable_irq)
  );

  // ----------------------------------------------------------------
  // Control two register
  // ----------------------------------------------------------------
  // Firmware may drop sleep enable once it has acted on the request
  assign control_clr = {2'h0, EC_CLR_SLEEP_EN, 5'h00};

  apm1_host_reg
  #(
    .WIDTH (8),
    .MASK  (`APM1_CTL_MASK),
    .RESET (`APM1_RST_CONTROL)
  )
  u_control
  (
    .CLK_SYS (CLK_SYS),
    .RST_B   (RST_B),
    .wr      (HOST_WR_CONTROL),
    .wdata   (HOST_WDATA),
    .ec_clr  (control_clr),
    .q       (control),
    .next_q  (next_control),
    .wr_irq  (control_irq)
  );

  assign STATUS_TWO             = status;
  assign ENABLE_TWO             = enable;
  assign CONTROL_TWO            = control;
  assign HOST_STATUS_WRITE_IRQ  = status_irq;
  assign HOST_ENABLE_WRITE_IRQ  = enable_irq;
  assign HOST_CONTROL_WRITE_IRQ = control_irq;

  // ----------------------------------------------------------------
  // Firmware SCI request
  // ----------------------------------------------------------------
  always @*
  begin
    next_fw_request = FIRMWARE_SCI_REQUEST;
    if (EC_WR_SCI_REQUEST)
    begin
      next_fw_request = HOST_SCI_OUT_N_REQUEST_DATA;
    end
  end

  // ----------------------------------------------------------------
  // SCI line
  // ----------------------------------------------------------------
  // Built from next values so the flop matches the registered bits
  // in the same cycle; the wake and power override status bits never drive it
  always @*
  begin
    next_sci_n = ~(
      (next_status[`APM1_STS_POWER_BUTTON] &
       next_enable[`APM1_EN_POWER_BUTTON]) |
      (next_status[`APM1_STS_SLEEP_BUTTON] &
       next_enable[`APM1_EN_SLEEP_BUTTON]) |
      (next_status[`APM1_STS_RTC_ALARM] &
       next_enable[`APM1_EN_RTC_ALARM]) |
      next_fw_request);
  end

  // ----------------------------------------------------------------
  // Low-power handshake
  // ----------------------------------------------------------------
  // Ack only once no host write pulse is still in flight
  always @*
  begin
    next_low_power_ack = LOW_POWER_REQ & ~HOST_WR_STATUS &
                         ~HOST_WR_ENABLE & ~HOST_WR_CONTROL &
                         ~status_irq & ~enable_irq & ~control_irq;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FIRMWARE_SCI_REQUEST  <= `APM1_RST_FW_REQUEST;
      POWER_OVERRIDE_ENABLE <= 1'h0;
      SLEEP_TYPE            <= 3'h0;
      SLEEP_ENABLE          <= 1'h0;
      HOST_SCI_OUT_N        <= 1'h1;
      LOW_POWER_ACK         <= 1'h0;
    end
    else
    begin
      FIRMWARE_SCI_REQUEST  <= next_fw_request;
      POWER_OVERRIDE_ENABLE <= next_control[`APM1_CTL_OVERRIDE_EN];
      SLEEP_TYPE            <=
        next_control[`APM1_CTL_SLEEP_TYPE_HI:`APM1_CTL_SLEEP_TYPE_LO];
      SLEEP_ENABLE          <= next_control[`APM1_CTL_SLEEP_EN];
      HOST_SCI_OUT_N        <= next_sci_n;
      LOW_POWER_ACK         <= next_low_power_ack;
    end
  end
endmodule // apm1_event_block

// file: tb/apm1_event_chk.sv
// Port-level assertion checker for the PM1 event block
`timescale 1ns/10ps

module apm1_event_chk
(
  input wire       CLK_SYS,
  input wire       RST_B,
  input wire       HOST_WR_STATUS,
  input wire       HOST_WR_ENABLE,
  input wire       HOST_WR_CONTROL,
  input wire [7:0] HOST_WDATA,
  input wire       EC_WR_STATUS,
  input wire [7:0] EC_STATUS_DATA,
  input wire       LOW_POWER_REQ,
  input wire [7:0] STATUS_TWO,
  input wire [7:0] ENABLE_TWO,
  input wire       FIRMWARE_SCI_REQUEST,
  input wire       POWER_OVERRIDE_ENABLE,
  input wire       HOST_SCI_OUT_N,
  input wire       HOST_CONTROL_WRITE_IRQ,
  input wire       HOST_ENABLE_WRITE_IRQ,
  input wire       HOST_STATUS_WRITE_IRQ,
  input wire       LOW_POWER_ACK
);
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  a_sci_pairs: assert property (
    HOST_SCI_OUT_N == !((|(STATUS_TWO[2:0] & ENABLE_TWO[2:0]))
                        || FIRMWARE_SCI_REQUEST))
    else $error("sci level wrong");
  a_ctl_irq_pulse: assert property (
    1'b1 |=> HOST_CONTROL_WRITE_IRQ == $past(HOST_WR_CONTROL))
    else $error("control irq wrong");
  a_en_irq_pulse: assert property (
    1'b1 |=> HOST_ENABLE_WRITE_IRQ == $past(HOST_WR_ENABLE))
    else $error("enable irq wrong");
  a_sts_irq_pulse: assert property (
    1'b1 |=> HOST_STATUS_WRITE_IRQ == $past(HOST_WR_STATUS))
    else $error("status irq wrong");
  a_host_one_clears: assert property (
    HOST_WR_STATUS && !EC_WR_STATUS
    |=> (STATUS_TWO & $past(HOST_WDATA)) == 8'h00)
    else $error("host one did not clear");
  a_host_zero_keeps: assert property (
    HOST_WR_STATUS && !EC_WR_STATUS
    |=> (STATUS_TWO & ~$past(HOST_WDATA))
        == ($past(STATUS_TWO) & ~$past(HOST_WDATA)))
    else $error("host zero changed status");
  a_ec_sets_status: assert property (
    EC_WR_STATUS |=> STATUS_TWO == ($past(EC_STATUS_DATA) & 8'h8F))
    else $error("firmware status write wrong");
  a_enable_host_only: assert property (
    !HOST_WR_ENABLE |=> $stable(ENABLE_TWO))
    else $error("enable changed without host");
  a_override_bit_one: assert property (
    HOST_WR_CONTROL
    |=> POWER_OVERRIDE_ENABLE == |($past(HOST_WDATA) & 8'h02))
    else $error("override enable wrong");
  a_lp_ack_drop: assert property (
    $fell(LOW_POWER_REQ) |=> !LOW_POWER_ACK)
    else $error("low power ack stuck");

  // Cheap evidence that the main paths were exercised
  c_fw_sci: cover property (FIRMWARE_SCI_REQUEST && !HOST_SCI_OUT_N);
  c_b2b: cover property (HOST_WR_CONTROL ##1 HOST_WR_ENABLE);
  c_lp: cover property (LOW_POWER_ACK);
endmodule // apm1_event_chk

bind apm1_event_block apm1_event_chk apm1_event_chk_i (.*);

// file: tb/apm1_host_model.sv
// Host-side model that writes the host registers
`timescale 1ns/10ps

module apm1_host_model
(
  input  wire       CLK_SYS,
  input  wire [7:0] STATUS_TWO,
  output reg        HOST_WR_STATUS,
  output reg        HOST_WR_ENABLE,
  output reg        HOST_WR_CONTROL,
  output reg  [7:0] HOST_WDATA
);
  initial
  begin
    {HOST_WR_CONTROL, HOST_WR_ENABLE, HOST_WR_STATUS} = 3'b000;
    HOST_WDATA = 8'h00;
  end

  // Raise only; calls may run back to back, idle ends a burst
  task wr(input [2:0] sel, input [7:0] d);
    begin
      @(posedge CLK_SYS);
      {HOST_WR_CONTROL, HOST_WR_ENABLE, HOST_WR_STATUS} <= sel;
      HOST_WDATA <= d;
    end
  endtask

  // Released data flips so a stale byte never looks valid
  task idle;
    begin
      @(posedge CLK_SYS);
      {HOST_WR_CONTROL, HOST_WR_ENABLE, HOST_WR_STATUS} <= 3'b000;
      HOST_WDATA <= ~HOST_WDATA;
    end
  endtask

  // Acknowledge pending events by writing ones back
  task service;
    begin
      wr(3'b001, STATUS_TWO);
      idle;
    end
  endtask
endmodule // apm1_host_model

// file: tb/tb.sv
// Self-checking bench for the PM1 event block
`timescale 1ns/10ps

module tb;
  reg        CLK_SYS = 1'b0;
  reg        RST_B = 1'b0;
  reg        EC_WR_STATUS = 1'b0;
  reg  [7:0] EC_STATUS_DATA = 8'h00;
  reg        EC_WR_SCI_REQUEST = 1'b0;
  reg        HOST_SCI_OUT_N_REQUEST_DATA = 1'b0;
  reg        EC_CLR_SLEEP_EN = 1'b0;
  reg        LOW_POWER_REQ = 1'b0;
  wire       HOST_WR_STATUS, HOST_WR_ENABLE, HOST_WR_CONTROL;
  wire [7:0] HOST_WDATA, STATUS_TWO, ENABLE_TWO, CONTROL_TWO;
  wire [2:0] SLEEP_TYPE;
  wire       FIRMWARE_SCI_REQUEST, POWER_OVERRIDE_ENABLE, SLEEP_ENABLE;
  wire       HOST_SCI_OUT_N, LOW_POWER_ACK, HOST_STATUS_WRITE_IRQ;
  wire       HOST_CONTROL_WRITE_IRQ, HOST_ENABLE_WRITE_IRQ;
  integer    err_count = 0;
  integer    checks = 0;
  integer    irq_n = 0;
  integer    i;

  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS)
    irq_n <= irq_n + HOST_CONTROL_WRITE_IRQ + HOST_ENABLE_WRITE_IRQ
             + HOST_STATUS_WRITE_IRQ;

  apm1_event_block apm1_event_block_i (.*);
  apm1_host_model  apm1_host_model_i (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task ec(input [7:0] d);
    begin
      @(posedge CLK_SYS);
      EC_WR_STATUS <= 1'b1;
      EC_STATUS_DATA <= d;
      @(posedge CLK_SYS);
      EC_WR_STATUS <= 1'b0;
      #1;
    end
  endtask

  task req(input d);
    begin
      @(posedge CLK_SYS);
      EC_WR_SCI_REQUEST <= 1'b1;
      HOST_SCI_OUT_N_REQUEST_DATA <= d;
      @(posedge CLK_SYS);
      EC_WR_SCI_REQUEST <= 1'b0;
      #1;
    end
  endtask

  task hw(input [2:0] s, input [7:0] d);
    begin
      apm1_host_model_i.wr(s, d);
      apm1_host_model_i.idle;
      #1;
    end
  endtask

  task report_and_stop;
    begin
      if (err_count == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      @(posedge CLK_SYS);
      RST_B <= 1'b0;
      repeat (12) @(posedge CLK_SYS);
      #1;
      chk(STATUS_TWO | ENABLE_TWO | CONTROL_TWO, 8'h00);
      chk({HOST_SCI_OUT_N, FIRMWARE_SCI_REQUEST, LOW_POWER_ACK,
           HOST_CONTROL_WRITE_IRQ, HOST_ENABLE_WRITE_IRQ,
           HOST_STATUS_WRITE_IRQ}, 8'h20);
      @(posedge CLK_SYS);
      RST_B <= 1'b1;
    end
  endtask

  task t_pairs;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        ec(8'h01 << i);
        chk(HOST_SCI_OUT_N, 8'h01);
        hw(3'b010, 8'h01 << i);
        chk(HOST_SCI_OUT_N, 8'h00);
        hw(3'b001, ~(8'h01 << i));
        chk(STATUS_TWO, 8'h01 << i);
        hw(3'b001, 8'h01 << i);
        chk({STATUS_TWO[6:0], HOST_SCI_OUT_N}, 8'h01);
      end
      ec(8'hFF);
      chk(STATUS_TWO, 8'h8F);
      chk(ENABLE_TWO, 8'h04);
      hw(3'b010, 8'hFF);
      chk(ENABLE_TWO, 8'h07);
      ec(8'h88);
      chk({STATUS_TWO[7:1], HOST_SCI_OUT_N}, 8'h89);
      apm1_host_model_i.service;
      #1;
      chk(STATUS_TWO, 8'h00);
    end
  endtask

  task t_fwreq;
    begin
      req(1'b1);
      chk({FIRMWARE_SCI_REQUEST, HOST_SCI_OUT_N}, 8'h02);
      req(1'b0);
      chk({FIRMWARE_SCI_REQUEST, HOST_SCI_OUT_N}, 8'h01);
    end
  endtask

  task t_irq;
    begin
      i = irq_n;
      apm1_host_model_i.wr(3'b100, 8'hFF);
      apm1_host_model_i.wr(3'b010, 8'h00);
      apm1_host_model_i.wr(3'b001, 8'h00);
      apm1_host_model_i.idle;
      #1;
      chk({HOST_CONTROL_WRITE_IRQ, HOST_ENABLE_WRITE_IRQ,
           HOST_STATUS_WRITE_IRQ}, 8'h01);
      chk(CONTROL_TWO, 8'h3E);
      chk({POWER_OVERRIDE_ENABLE, SLEEP_TYPE, SLEEP_ENABLE}, 8'h1F);
      @(posedge CLK_SYS);
      EC_CLR_SLEEP_EN <= 1'b1;
      @(posedge CLK_SYS);
      EC_CLR_SLEEP_EN <= 1'b0;
      #1;
      chk(irq_n - i, 8'h03);
      chk({SLEEP_ENABLE, CONTROL_TWO[6:0]}, 8'h1E);
      hw(3'b100, 8'h02);
      chk(CONTROL_TWO, 8'h02);
    end
  endtask

  task t_lowpower;
    begin
      hw(3'b010, 8'h05);
      @(posedge CLK_SYS);
      LOW_POWER_REQ <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      #1;
      chk({LOW_POWER_ACK, ENABLE_TWO[6:0]}, 8'h85);
      @(posedge CLK_SYS);
      LOW_POWER_REQ <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      #1;
      chk(LOW_POWER_ACK, 8'h00);
    end
  endtask

  // Whole run is under a hundred cycles; this margin is generous
  initial
  begin
    #100000;
    err_count = err_count + 1;
    report_and_stop;
  end

  initial
  begin
    t_reset;
    t_pairs;
    t_fwreq;
    t_irq;
    t_lowpower;
    ec(8'h07);
    t_reset;
    report_and_stop;
  end
endmodule // tb
